// ---- logic/scrc_pkg.sv ----
package scrc_pkg;

  // ******************************************************************
  // port addresses (only the low eight address bits are decoded)
  // ******************************************************************
  localparam logic [5:0] PORT_PAGE = 6'h38;
  localparam logic [7:0] ADDR_A_CTRL = 8'hE0;
  localparam logic [7:0] ADDR_A_DATA = 8'hE1;
  localparam logic [7:0] ADDR_B_CTRL = 8'hE2;
  localparam logic [7:0] ADDR_B_DATA = 8'hE3;

  // ******************************************************************
  // register indices behind the pointer
  // ******************************************************************
  localparam logic [3:0] REG_BASE = 4'h0;
  localparam logic [3:0] REG_STAT1 = 4'h1;
  localparam logic [3:0] REG_VECTOR = 4'h2;
  localparam logic [3:0] REG_IP = 4'h3;
  localparam logic [3:0] REG_RB_WR4 = 4'h4;
  localparam logic [3:0] REG_RB_WR5 = 4'h5;
  localparam logic [3:0] REG_FIFO_LO = 4'h6;
  localparam logic [3:0] REG_EXT = 4'h7;
  localparam logic [3:0] REG_FIFO_HI = 4'h7;
  localparam logic [3:0] REG_RXBUF = 4'h8;
  localparam logic [3:0] REG_MASTER = 4'h9;
  localparam logic [3:0] REG_RB_WR3 = 4'h9;
  localparam logic [3:0] REG_PRESET = 4'hA;
  localparam logic [3:0] REG_BAUD_LO = 4'hC;
  localparam logic [3:0] REG_BAUD_HI = 4'hD;
  localparam logic [3:0] REG_RB_WR7 = 4'hE;
  localparam logic [3:0] REG_EXTINT = 4'hF;
  localparam logic [3:0] REG_WR3 = 4'h3;

  // ******************************************************************
  // field positions and codes
  // ******************************************************************
  localparam int EXT_CRC32_BIT = 7;
  localparam int EXT_RDBACK_BIT = 6;
  localparam int EXTINT_EXT_BIT = 0;
  localparam int EXTINT_FIFO_BIT = 2;
  localparam int STAT1_CRC_BIT = 6;
  localparam int PRESET_ONES_BIT = 7;
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam logic [1:0] MASTER_HW_RESET = 2'h3;
  localparam logic [2:0] IPC_A_RX = 3'h6;
  localparam logic [2:0] IPC_B_RX = 3'h2;
  localparam logic [2:0] IPC_NONE = 3'h3;
  localparam logic [31:0] CRC16_POLY = 32'h0000_1021;
  localparam logic [31:0] CRC32_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC16_MASK = 32'h0000_FFFF;
  localparam int FIFO_W = 19;

  // ******************************************************************
  // channel-side carriers
  // ******************************************************************
  typedef struct packed {
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_start;
    logic rx_bit_en;
    logic rx_bit;
    logic rx_end;
    logic tx_start;
    logic tx_bit_en;
    logic tx_bit;
    logic tx_empty;
  } scrc_line_in_t;

  typedef struct packed {
    logic tx_stb;
    logic [7:0] tx_data;
    logic crc32_sel;
    logic [31:0] tx_crc;
  } scrc_line_out_t;

endpackage : scrc_pkg

// ---- logic/scrc_reg_access.sv ----
`timescale 1ns/1ps
// Behaviour
// - decode low address byte E0 to E3
// - data select high reaches data register directly
// - pointer written first, then value or read
// - pointer clears after indirect access
// - serial 32-bit CRC, Ethernet polynomial
// - extended bit 7 selects 32-bit CRC
// - override: only 32-bit CRC sent and checked
// - 32-bit result in status bit D6
// - 32-bit result stored in frame FIFO
// - CRC preset zeros or ones still works
// - override cleared by reset
// - never both CRC widths at once
// - core clock is system clock over one or two
// - divider set by enh_core_div2 input, not by reset
// - sixteen write registers, shared vector and master
// - extended register writable only with D0 set
// - FIFO reads only with D2 set
// - vector plain on A, modified on B; pending on A
// - baud constant low and high readable
// - UART host mode mutes B, routes its clock
module scrc_reg_access
  import scrc_pkg::*;
#(
  parameter int FIFO_DEPTH = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic io_iorq_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_data_oe,
  input wire logic enh_core_div2,
  input wire logic uart_host_en,
  input wire logic chan_b_txrx_clock,
  output logic core_clk_en,
  output logic host_timer_clk,
  input wire scrc_line_in_t [1:0] line_in,
  output scrc_line_out_t [1:0] line_out
);

  // ******************************************************************
  // parameters and state
  // ******************************************************************
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 15) begin : g_bad_depth
    $error("FIFO_DEPTH must lie in 2..15");
  end

  localparam logic [3:0] DEPTH4 = 4'(FIFO_DEPTH);
  localparam logic [3:0] LAST4 = 4'(FIFO_DEPTH - 1);

  typedef struct packed {
    logic [15:0][7:0] wr;
    logic [7:0] ext;
    logic [3:0] ptr;
    logic [7:0] rxbuf;
    logic rx_avail;
    logic [31:0] txcrc;
    logic [31:0] rxcrc;
    logic crc_err;
    logic [FIFO_DEPTH-1:0][FIFO_W-1:0] fifo;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [3:0] cnt;
    logic [13:0] bytes;
    logic tx_stb;
    logic [7:0] tx_data;
  } scrc_chan_t;

  typedef struct packed {
    scrc_chan_t [1:0] ch;
    logic [7:0] vec;
    logic [7:0] mic;
    logic [7:0] rdata;
    logic oe;
    logic rd_busy;
    logic wr_busy;
    logic div_tog;
    logic host_clk;
  } scrc_state_t;

  scrc_state_t s;
  scrc_state_t next_s;
  logic acc;
  logic rd_go;
  logic wr_go;

  // ******************************************************************
  // crc step
  // ******************************************************************
  // both widths shift msb-first, so 32-bit follows the 16-bit ordering
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b,
                                           input logic is32);
    logic fb;
    logic [31:0] n;
    fb = b ^ (is32 ? c[31] : c[15]);
    n = {c[30:0], 1'b0} ^ (fb ? (is32 ? CRC32_POLY : CRC16_POLY) : 32'h0000_0000);
    if (!is32) begin
      n = n & CRC16_MASK;
    end
    return n;
  endfunction : crc_step

  // ******************************************************************
  // bus decode
  // ******************************************************************
  assign acc = !io_iorq_n && (io_addr[7:2] == PORT_PAGE);
  assign rd_go = acc && !io_rd_n && !s.rd_busy;
  assign wr_go = acc && !io_wr_n && !s.wr_busy;

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    scrc_chan_t cs;
    logic c;
    logic [3:0] p;
    logic [FIFO_W-1:0] head;
    logic fen;
    logic rb;
    logic is32;
    logic [31:0] pre;
    logic [7:0] ip;
    logic [2:0] ipc;
    next_s = s;
    c = io_addr[1];
    cs = s.ch[c];
    p = cs.ptr;
    head = cs.fifo[cs.rp];
    fen = cs.wr[REG_EXTINT][EXTINT_FIFO_BIT];
    rb = cs.ext[EXT_RDBACK_BIT];
    is32 = 1'b0;
    pre = 32'h0000_0000;
    ip = {2'b00, s.ch[0].rx_avail, 2'b00, s.ch[1].rx_avail, 2'b00};
    ipc = s.ch[0].rx_avail ? IPC_A_RX : (s.ch[1].rx_avail ? IPC_B_RX : IPC_NONE);
    next_s.rd_busy = !io_rd_n;
    next_s.wr_busy = !io_wr_n;
    next_s.oe = acc && !io_rd_n;
    next_s.div_tog = enh_core_div2 ? !s.div_tog : 1'b0;
    next_s.host_clk = uart_host_en && chan_b_txrx_clock;
    next_s.ch[0].tx_stb = 1'b0;
    next_s.ch[1].tx_stb = 1'b0;

    // reads capture data and apply their side effects in the first cycle
    if (rd_go) begin
      if (io_addr[0]) begin
        next_s.rdata = cs.rxbuf;
        next_s.ch[c].rx_avail = 1'b0;
      end else begin
        case (p)
          REG_BASE: next_s.rdata = {5'h00, line_in[c].tx_empty, 1'b0, cs.rx_avail};
          REG_STAT1: next_s.rdata = {1'b0, cs.crc_err, 6'h01};
          REG_VECTOR: next_s.rdata = c ? {s.vec[7:4], ipc, s.vec[0]} : s.vec;
          REG_IP: next_s.rdata = c ? 8'h00 : ip;
          REG_RB_WR4: next_s.rdata = rb ? cs.wr[REG_RB_WR4] : 8'h00;
          REG_RB_WR5: next_s.rdata = rb ? cs.wr[REG_RB_WR5] : 8'h00;
          REG_FIFO_LO: next_s.rdata = (fen && cs.cnt != 4'h0) ? head[7:0] : 8'h00;
          REG_FIFO_HI: begin
            next_s.rdata = (fen && cs.cnt != 4'h0) ? {head[18:17], head[13:8]} : 8'h00;
            if (fen && cs.cnt != 4'h0) begin
              next_s.ch[c].rp = (cs.rp == LAST4) ? 4'h0 : cs.rp + 4'h1;
              next_s.ch[c].cnt = cs.cnt - 4'h1;
            end
          end
          REG_RXBUF: next_s.rdata = cs.rxbuf;
          REG_RB_WR3: next_s.rdata = rb ? cs.wr[REG_WR3] : 8'h00;
          REG_BAUD_LO: next_s.rdata = cs.wr[REG_BAUD_LO];
          REG_BAUD_HI: next_s.rdata = cs.wr[REG_BAUD_HI];
          REG_RB_WR7: next_s.rdata = rb ? cs.wr[REG_EXT] : 8'h00;
          REG_EXTINT: next_s.rdata = cs.wr[REG_EXTINT];
          default: next_s.rdata = 8'h00;
        endcase
        next_s.ch[c].ptr = 4'h0;
      end
    end

    if (wr_go) begin
      if (io_addr[0]) begin
        next_s.ch[c].tx_stb = 1'b1;
        next_s.ch[c].tx_data = io_wdata;
      end else if (p == REG_BASE) begin
        // base command carries the pointer; point-high adds bit 3
        next_s.ch[c].ptr = {io_wdata[5:3] == CMD_POINT_HIGH, io_wdata[2:0]};
        next_s.ch[c].wr[REG_BASE] = io_wdata;
      end else begin
        case (p)
          REG_VECTOR: next_s.vec = io_wdata;
          REG_MASTER: begin
            next_s.mic = io_wdata;
            if (io_wdata[7:6] == MASTER_HW_RESET) begin
              next_s.ch[0].ext = 8'h00;
              next_s.ch[1].ext = 8'h00;
            end
          end
          REG_EXT: begin
            if (cs.wr[REG_EXTINT][EXTINT_EXT_BIT]) begin
              next_s.ch[c].ext = io_wdata;
            end else begin
              next_s.ch[c].wr[REG_EXT] = io_wdata;
            end
          end
          default: next_s.ch[c].wr[p] = io_wdata;
        endcase
        next_s.ch[c].ptr = 4'h0;
      end
    end

    // channel events; a received byte sets its flag over a same-cycle read
    for (int i = 0; i < 2; i++) begin
      is32 = s.ch[i].ext[EXT_CRC32_BIT];
      pre = s.ch[i].wr[REG_PRESET][PRESET_ONES_BIT] ? 32'hFFFF_FFFF : 32'h0000_0000;
      if (!is32) begin
        pre = pre & CRC16_MASK;
      end
      if (line_in[i].tx_start) begin
        next_s.ch[i].txcrc = pre;
      end else if (line_in[i].tx_bit_en) begin
        next_s.ch[i].txcrc = crc_step(s.ch[i].txcrc, line_in[i].tx_bit, is32);
      end
      if (line_in[i].rx_start) begin
        next_s.ch[i].rxcrc = pre;
        next_s.ch[i].bytes = 14'h0000;
      end else if (line_in[i].rx_bit_en) begin
        next_s.ch[i].rxcrc = crc_step(s.ch[i].rxcrc, line_in[i].rx_bit, is32);
      end
      if (line_in[i].rx_valid) begin
        next_s.ch[i].rxbuf = line_in[i].rx_data;
        next_s.ch[i].rx_avail = 1'b1;
        next_s.ch[i].bytes = s.ch[i].bytes + 14'h0001;
      end
      // residue of data plus appended crc is zero when the frame is good
      if (line_in[i].rx_end) begin
        next_s.ch[i].crc_err = (s.ch[i].rxcrc != 32'h0000_0000);
        next_s.ch[i].bytes = 14'h0000;
        // a full FIFO drops the new entry rather than overwrite history
        if (next_s.ch[i].cnt != DEPTH4) begin
          next_s.ch[i].fifo[s.ch[i].wp] = {is32, s.ch[i].rxcrc == 32'h0000_0000, 3'b000,
                                           s.ch[i].bytes};
          next_s.ch[i].wp = (s.ch[i].wp == LAST4) ? 4'h0 : s.ch[i].wp + 4'h1;
          next_s.ch[i].cnt = next_s.ch[i].cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign io_rdata = s.rdata;
  assign io_data_oe = s.oe;
  assign core_clk_en = !enh_core_div2 || s.div_tog;
  assign host_timer_clk = s.host_clk;

  for (genvar g = 0; g < 2; g++) begin : g_line
    assign line_out[g].tx_stb = s.ch[g].tx_stb && !(g == 1 && uart_host_en);
    assign line_out[g].tx_data = s.ch[g].tx_data;
    assign line_out[g].crc32_sel = s.ch[g].ext[EXT_CRC32_BIT];
    assign line_out[g].tx_crc = s.ch[g].txcrc;
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  a_ptr_clear: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr != 4'h0) |=> s.ch[0].ptr == 4'h0)
    else $error("pointer not cleared after indirect write");

  a_ext_gate: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_EXT
     && !s.ch[0].wr[REG_EXTINT][EXTINT_EXT_BIT]) |=> $stable(s.ch[0].ext))
    else $error("extended register written while locked");

  a_div_one: assert property (@(posedge clk) disable iff (!rstn)
    !enh_core_div2 |-> core_clk_en)
    else $error("core enable missing in divide-by-one");

  a_div_two: assert property (@(posedge clk) disable iff (!rstn)
    (enh_core_div2 && core_clk_en ##1 enh_core_div2) |-> !core_clk_en)
    else $error("core enable too frequent in divide-by-two");

  a_data_direct: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && io_addr == ADDR_A_DATA) |=>
      line_out[0].tx_stb && line_out[0].tx_data == $past(io_wdata))
    else $error("data port write not passed straight through");

  a_fifo_gate: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_FIFO_LO
     && !s.ch[0].wr[REG_EXTINT][EXTINT_FIFO_BIT]) |=> io_rdata == 8'h00)
    else $error("frame FIFO readable while disabled");

  a_crc_status: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_STAT1) |=>
      io_rdata[STAT1_CRC_BIT] == $past(s.ch[0].crc_err) && io_data_oe)
    else $error("crc result missing from status bit 6");

  a_ip_b_zero: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_B_CTRL && s.ch[1].ptr == REG_IP) |=> io_rdata == 8'h00)
    else $error("pending bits visible through channel B");

  a_uart_mute: assert property (@(posedge clk) disable iff (!rstn)
    uart_host_en |-> !line_out[1].tx_stb)
    else $error("channel B drives while host interface enabled");

  a_ptr_rd_clear: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_A_CTRL) |=> s.ch[0].ptr == 4'h0)
    else $error("pointer not cleared after indirect read");

  a_vec_plain: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_VECTOR) |=> io_rdata == $past(s.vec))
    else $error("vector modified on channel A");

  a_baud_read: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_BAUD_LO) |=>
      io_rdata == $past(s.ch[0].wr[REG_BAUD_LO]))
    else $error("baud constant low byte not returned");

  a_master_clr: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && io_addr == ADDR_A_CTRL && s.ch[0].ptr == REG_MASTER
     && io_wdata[7:6] == MASTER_HW_RESET) |=> s.ch[0].ext == 8'h00 && s.ch[1].ext == 8'h00)
    else $error("crc override survives hardware reset command");

  a_crc_narrow: assert property (@(posedge clk) disable iff (!rstn)
    (!s.ch[0].ext[EXT_CRC32_BIT] && (line_in[0].tx_start || line_in[0].tx_bit_en)) |=>
      s.ch[0].txcrc[31:16] == 16'h0000)
    else $error("upper crc bits active in 16-bit mode");

  a_fifo_push: assert property (@(posedge clk) disable iff (!rstn)
    (line_in[0].rx_end && s.ch[0].ext[EXT_CRC32_BIT] && s.ch[0].cnt != DEPTH4) |=>
      s.ch[0].fifo[$past(s.ch[0].wp)][FIFO_W-1]
      && s.ch[0].fifo[$past(s.ch[0].wp)][FIFO_W-2] == ($past(s.ch[0].rxcrc) == 32'h0000_0000))
    else $error("32-bit crc result missing from frame FIFO");

endmodule : scrc_reg_access

// ---- verif/scrc_cpu_model.sv ----
`timescale 1ns/1ps
module scrc_cpu_model
  import scrc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  input wire logic io_data_oe,
  output logic io_iorq_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    io_iorq_n = 1'b1;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_addr = 8'h00;
    io_wdata = 8'h00;
  end
  // ********
  // bus cycles
  // ********
  // strobe low over one rising edge, then two idle cycles before the next take
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    @(negedge clk);
    io_iorq_n = 1'b0;
    io_addr = a;
    io_wdata = d;
    io_wr_n = !wr;
    io_rd_n = wr;
    @(negedge clk);
    q = io_rdata;
    oe = io_data_oe;
    io_iorq_n = 1'b1;
    io_wr_n = 1'b1;
    io_rd_n = 1'b1;
    // released lines must not keep the old value
    io_wdata = ~d;
    io_addr = ~a;
    @(negedge clk);
  endtask : acc
  task automatic wreg(input logic ch, input logic [3:0] idx, input logic [7:0] v);
    logic [7:0] q;
    logic oe;
    acc(1'b1, {PORT_PAGE, ch, 1'b0}, {4'h0, idx}, q, oe);
    acc(1'b1, {PORT_PAGE, ch, 1'b0}, v, q, oe);
  endtask : wreg
  task automatic rreg(input logic ch, input logic [3:0] idx, output logic [7:0] q);
    logic oe;
    acc(1'b1, {PORT_PAGE, ch, 1'b0}, {4'h0, idx}, q, oe);
    acc(1'b0, {PORT_PAGE, ch, 1'b0}, 8'h00, q, oe);
  endtask : rreg
endmodule : scrc_cpu_model

// ---- verif/tb_scrc_reg_access.sv ----
`timescale 1ns/1ps
module tb_scrc_reg_access
  import scrc_pkg::*;
();
  logic clk;
  logic rstn;
  logic io_iorq_n;
  logic io_rd_n;
  logic io_wr_n;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_data_oe;
  logic enh_core_div2;
  logic uart_host_en;
  logic chan_b_txrx_clock;
  logic core_clk_en;
  logic host_timer_clk;
  scrc_line_in_t [1:0] line_in;
  scrc_line_out_t [1:0] line_out;
  int fail_count = 0;
  int n_tests = 0;
  int stb_a = 0;
  int stb_b = 0;
  int n;
  logic [7:0] q;
  logic oe;
  logic [31:0] c;

  scrc_reg_access i_dut (.clk(clk), .rstn(rstn), .io_iorq_n(io_iorq_n),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_data_oe(io_data_oe), .enh_core_div2(enh_core_div2),
    .uart_host_en(uart_host_en), .chan_b_txrx_clock(chan_b_txrx_clock),
    .core_clk_en(core_clk_en), .host_timer_clk(host_timer_clk),
    .line_in(line_in), .line_out(line_out));
  scrc_cpu_model i_cpu (.clk(clk), .io_rdata(io_rdata), .io_data_oe(io_data_oe),
    .io_iorq_n(io_iorq_n), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .io_addr(io_addr), .io_wdata(io_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (line_out[0].tx_stb === 1'b1) stb_a++;
    if (line_out[1].tx_stb === 1'b1) stb_b++;
  end
  // ********
  // checking and verdict
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
  // ********
  // channel A line events
  // ********
  // bits are all ones; byte pulses carry no bits, so only nb moves the crc
  task automatic frame(input int nb, input int nv);
    @(negedge clk);
    line_in[0].rx_start = 1'b1;
    @(negedge clk);
    line_in[0].rx_start = 1'b0;
    for (int i = 0; i < nb + nv; i++) begin
      @(negedge clk);
      line_in[0].rx_bit_en = (i < nb);
      line_in[0].rx_valid = (i >= nb);
      @(negedge clk);
      line_in[0].rx_bit_en = 1'b0;
      line_in[0].rx_valid = 1'b0;
    end
    @(negedge clk);
    line_in[0].rx_end = 1'b1;
    @(negedge clk);
    line_in[0].rx_end = 1'b0;
  endtask : frame
  task automatic tx_one(output logic [31:0] crc);
    @(negedge clk);
    line_in[0].tx_start = 1'b1;
    @(negedge clk);
    line_in[0].tx_start = 1'b0;
    line_in[0].tx_bit_en = 1'b1;
    @(negedge clk);
    line_in[0].tx_bit_en = 1'b0;
    crc = line_out[0].tx_crc;
  endtask : tx_one
  // ********
  // main sequence
  // ********
  initial begin
    rstn = 1'b0;
    line_in = '0;
    line_in[0].tx_empty = 1'b1;
    line_in[0].rx_data = 8'h3C;
    line_in[0].tx_bit = 1'b1;
    line_in[0].rx_bit = 1'b1;
    enh_core_div2 = 1'b0;
    uart_host_en = 1'b0;
    chan_b_txrx_clock = 1'b0;
    repeat (10) @(negedge clk);
    chk("oe_rst", io_data_oe, 1'b0);
    chk("sel_rst", line_out[0].crc32_sel, 1'b0);
    chk("clken_rst", core_clk_en, 1'b1);
    rstn = 1'b1;
    i_cpu.acc(1'b0, 8'hE4, 8'h00, q, oe);
    chk("oe_unmapped", oe, 1'b0);
    i_cpu.acc(1'b0, ADDR_A_CTRL, 8'h00, q, oe);
    chk("base_stat", {oe, q}, 9'h104);
    i_cpu.acc(1'b1, ADDR_A_DATA, 8'h96, q, oe);
    chk("stb_a", stb_a, 1);
    chk("tx_data", line_out[0].tx_data, 8'h96);
    i_cpu.wreg(1'b0, 4'hC, 8'h5A);
    i_cpu.wreg(1'b0, 4'hD, 8'hA5);
    i_cpu.acc(1'b0, ADDR_A_CTRL, 8'h00, q, oe);
    chk("ptr_clear", q, 8'h04);
    i_cpu.rreg(1'b0, REG_BAUD_LO, q);
    chk("baud_lo", q, 8'h5A);
    i_cpu.rreg(1'b0, REG_BAUD_HI, q);
    chk("baud_hi", q, 8'hA5);
    i_cpu.wreg(1'b1, REG_VECTOR, 8'hF1);
    i_cpu.rreg(1'b0, REG_VECTOR, q);
    chk("vec_a", q, 8'hF1);
    i_cpu.rreg(1'b1, REG_VECTOR, q);
    chk("vec_b", q, 8'hF7);
    i_cpu.rreg(1'b1, REG_IP, q);
    chk("ip_b", q, 8'h00);
    tx_one(c);
    chk("crc16", c, CRC16_POLY);
    i_cpu.wreg(1'b0, REG_EXT, 8'hC0);
    chk("ext_locked", line_out[0].crc32_sel, 1'b0);
    i_cpu.rreg(1'b0, REG_RB_WR7, q);
    chk("rb_off", q, 8'h00);
    i_cpu.wreg(1'b0, REG_EXTINT, 8'h01);
    i_cpu.wreg(1'b0, REG_EXT, 8'hC0);
    chk("sel32", line_out[0].crc32_sel, 1'b1);
    i_cpu.rreg(1'b0, REG_RB_WR7, q);
    chk("rb_wr7", q, 8'hC0);
    tx_one(c);
    chk("crc32", c, CRC32_POLY);
    frame(0, 2);
    i_cpu.rreg(1'b0, REG_IP, q);
    chk("ip_a", q, 8'h20);
    i_cpu.acc(1'b0, ADDR_A_DATA, 8'h00, q, oe);
    chk("rx_data", q, 8'h3C);
    i_cpu.rreg(1'b0, REG_STAT1, q);
    chk("stat_ok", q, 8'h01);
    i_cpu.rreg(1'b0, REG_FIFO_LO, q);
    chk("fifo_gated", q, 8'h00);
    i_cpu.wreg(1'b0, REG_EXTINT, 8'h05);
    i_cpu.rreg(1'b0, REG_FIFO_LO, q);
    chk("fifo_lo", q, 8'h02);
    i_cpu.rreg(1'b0, REG_FIFO_HI, q);
    chk("fifo_hi", q, 8'hC0);
    frame(1, 0);
    i_cpu.rreg(1'b0, REG_STAT1, q);
    chk("stat_bad", q, 8'h41);
    i_cpu.rreg(1'b0, REG_FIFO_HI, q);
    chk("fifo_bad", q, 8'h80);
    i_cpu.wreg(1'b0, REG_PRESET, 8'h80);
    frame(0, 0);
    i_cpu.rreg(1'b0, REG_FIFO_HI, q);
    chk("preset_ones", q, 8'h80);
    i_cpu.wreg(1'b0, REG_MASTER, 8'hC0);
    chk("sel_master", line_out[0].crc32_sel, 1'b0);
    enh_core_div2 = 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (core_clk_en === 1'b1) n++;
    end
    chk("div2", n, 4);
    uart_host_en = 1'b1;
    chan_b_txrx_clock = 1'b1;
    i_cpu.acc(1'b1, ADDR_B_DATA, 8'h11, q, oe);
    chk("stb_b_muted", stb_b, 0);
    chk("timer_clk", host_timer_clk, 1'b1);
    chan_b_txrx_clock = 1'b0;
    repeat (2) @(negedge clk);
    chk("timer_clk_lo", host_timer_clk, 1'b0);
    i_cpu.wreg(1'b0, REG_EXT, 8'h80);
    chk("sel_again", line_out[0].crc32_sel, 1'b1);
    rstn = 1'b0;
    @(negedge clk);
    chk("sel_rst2", line_out[0].crc32_sel, 1'b0);
    rstn = 1'b1;
    @(negedge clk);
    test_done();
  end
endmodule : tb_scrc_reg_access
